// [bench/rpc_attr_model.sv]
// Behavioural model of the region attribute block beside the control.
// Assumes software writes reach it as a one-cycle set pulse.
`timescale 1ns/1ns
module rpc_attr_model (
   // Clock, reset and selector
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] region_select_i,
   // Attribute write from software
   input wire logic set_i,
   input wire logic [4:0] size_i,
   input wire logic enable_i,
   input wire logic [2:0] ap_i,
   // Settings of all regions
   output logic [39:0] size_o,
   output logic [7:0] enable_o,
   output logic [23:0] ap_o
);
   // ------------------------------------------------------------------
   // Region settings
   // ------------------------------------------------------------------
   // A write lands on the region named by the selector; a selector
   // above 7 names no region, so such a write is lost.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         size_o <= {8{5'h07}};
         enable_o <= 8'h00;
         ap_o <= 24'h000000;
      end else if (set_i && region_select_i < 8'h08) begin
         size_o[region_select_i[2:0]*5 +: 5] <= size_i;
         enable_o[region_select_i[2:0]] <= enable_i;
         ap_o[region_select_i[2:0]*3 +: 3] <= ap_i;
      end
   end
endmodule

// [bench/rpc_top_tb.sv]
// Self-checking bench of the region protection control block.
// Assumes the attribute model answers for region size, enable and access permission; the other settings are tied off.
`timescale 1ns/1ns
`include "rpc_params.svh"
module rpc_top_tb;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   localparam logic [7:0] CT = `RPC_OFS_CTRL;
   localparam logic [7:0] RS = `RPC_OFS_RSEL;
   localparam logic [7:0] RB = `RPC_OFS_RBASE;
   localparam logic [5:0] P = 6'h20, W = 6'h10, H = 6'h04;
   localparam logic [5:0] S = 6'h02, V = 6'h01;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, set = 1'b0, a_en = 1'b0;
   logic [7:0] rsel, en;
   logic [39:0] size;
   logic [23:0] ap;
   logic [4:0] a_size = 5'h07;
   logic [2:0] a_ap = 3'h0;
   logic acc_valid_i = 1'b0, acc_write_i = 1'b0, acc_fetch_i = 1'b0;
   logic acc_priv_i = 1'b0, acc_hfnmi_i = 1'b0, acc_scs_i = 1'b0;
   logic acc_vector_i = 1'b0;
   logic [31:0] acc_addr_i = 32'h00000000;
   logic chk_valid_o, fault_o, dflt_o, xn_o, so_o;
   logic [3:0] hit_o;
   logic [31:0] rd_q[$];
   logic [15:0] ck_q[$];
   logic [31:0] rnd;
   int n_fail = 0;
   int n_tests = 0;

   // Free-running processor clock, 100 ns period.
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // Size, enable and access permission come from the partner model; subregion, xn, c and b are tied to zero.
   rpc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .region_select_o(rsel),
      .region_size_i(size), .region_enable_i(en),
      .region_srd_i(64'h0000000000000000), .region_ap_i(ap),
      .region_xn_i(8'h00), .region_c_i(8'h00), .region_b_i(8'h00),
      .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i),
      .acc_write_i(acc_write_i), .acc_fetch_i(acc_fetch_i),
      .acc_priv_i(acc_priv_i), .acc_hfnmi_i(acc_hfnmi_i),
      .acc_scs_i(acc_scs_i), .acc_vector_i(acc_vector_i),
      .chk_valid_o(chk_valid_o), .fault_o(fault_o),
      .default_map_o(dflt_o), .execute_never_o(xn_o),
      .strongly_ordered_o(so_o), .hit_region_o(hit_o));
   rpc_attr_model far (.clk_i(clk_i), .rst_i(rst_i),
      .region_select_i(rsel), .set_i(set), .size_i(a_size),
      .enable_i(a_en), .ap_i(a_ap), .size_o(size), .enable_o(en),
      .ap_o(ap));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic test_done();
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic fail(input string s);
      n_fail++;
      $display("FAIL %0t %s", $time, s);
   endtask

   // One classic cycle; the request holds until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] a,
         input logic [31:0] d);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hF;
      wb_adr_i <= a;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      if (i >= 20) begin
         fail("no ack");
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 32'h00000000);
   endtask

   task automatic attr(input logic [4:0] s, input logic e,
         input logic [2:0] p);
      @(posedge clk_i);
      set <= 1'b1;
      a_size <= s;
      a_en <= e;
      a_ap <= p;
      @(posedge clk_i);
      set <= 1'b0;
   endtask

   // Expected byte is {fault, default map, xn, so, hit region}.
   task automatic acc(input logic [31:0] a, input logic [5:0] f,
         input logic [7:0] m, input logic [7:0] e);
      @(posedge clk_i);
      acc_valid_i <= 1'b1;
      acc_addr_i <= a;
      {acc_priv_i, acc_write_i, acc_fetch_i, acc_hfnmi_i, acc_scs_i,
         acc_vector_i} <= f;
      ck_q.push_back({m, e});
   endtask

   task automatic acc_stop();
      @(posedge clk_i);
      acc_valid_i <= 1'b0;
   endtask

   task automatic cmp_rd();
      logic [31:0] e;
      n_tests++;
      if (rd_q.size() == 0) begin
         fail("read without note");
      end else begin
         e = rd_q.pop_front();
         if (wb_dat_o !== e) begin
            fail($sformatf("read %h want %h", wb_dat_o, e));
         end
      end
   endtask

   task automatic cmp_chk();
      logic [15:0] n;
      logic [7:0] g;
      n_tests++;
      g = {fault_o, dflt_o, xn_o, so_o, hit_o};
      if (ck_q.size() == 0) begin
         fail("check without note");
      end else begin
         n = ck_q.pop_front();
         if ((g & n[15:8]) !== (n[7:0] & n[15:8])) begin
            fail($sformatf("check %h want %h", g, n[7:0]));
         end
      end
   endtask

   // Results are matched against notes in the order they were made.
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
         cmp_rd();
      end
      if (chk_valid_o === 1'b1) begin
         cmp_chk();
      end
   end

   // A hang counts as a mismatch; the normal run is far shorter.
   initial begin
      #1000000;
      n_fail++;
      test_done();
   end

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial begin
      rnd = $urandom(32206);
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(CT, 32'h00000000);
      rd(RB, 32'h00000000);
      wr(CT, 32'hFFFFFFFF);
      rd(CT, 32'h00000007);
      wr(RS, 32'hFFFFFFFF);
      rd(RS, 32'h000000FF);
      rd(RB, 32'h0000000F);
      wr(8'h0C, 32'hFFFFFFFF);
      rd(8'h0C, 32'h00000000);
      wr(RS, 32'h00000002);
      wr(RB, 32'h00001005);
      rd(RS, 32'h00000002);
      rd(RB, 32'h00001002);
      wr(RB, 32'h000020F5);
      rd(RS, 32'h00000005);
      rd(RB, 32'h00002005);
      wr(CT, 32'h00000000);
      // Back-to-back random checks with protection off.
      for (int i = 0; i < 20; i++) begin
         rnd = $urandom();
         acc(rnd, {rnd[3:0], 2'b00}, 8'hC0, 8'h40);
      end
      acc(32'hE000ED00, S, 8'hF0, 8'h70);
      acc_stop();
      wr(CT, 32'h00000004);
      acc(32'h00000100, 6'h00, 8'hC0, 8'h40);
      acc_stop();
      wr(CT, 32'h00000001);
      // A faulted miss leaves the default-map flag up; fault, flag and region are all checked.
      acc(32'h00000100, 6'h00, 8'hCF, 8'hCF);
      acc(32'h00000100, P, 8'hCF, 8'hCF);
      acc(32'h00000100, H, 8'hC0, 8'h40);
      acc(32'hE000ED00, S, 8'hF0, 8'h70);
      acc(32'h00000000, V, 8'hC0, 8'h40);
      acc_stop();
      wr(CT, 32'h00000003);
      acc(32'h00000100, H, 8'hC0, 8'hC0);
      acc_stop();
      wr(CT, 32'h00000005);
      acc(32'h00000100, P, 8'hCF, 8'h4F);
      acc(32'h00000100, 6'h00, 8'hCF, 8'hCF);
      acc_stop();
      wr(RS, 32'h00000003);
      attr(5'h0C, 1'b1, 3'b011);
      wr(RB, 32'h00000013);
      wr(RS, 32'h00000005);
      attr(5'h07, 1'b1, 3'b000);
      wr(RB, 32'h00001015);
      acc(32'h00000800, 6'h00, 8'hFF, 8'h13);
      acc(32'h00001010, 6'h00, 8'hCF, 8'h85);
      acc(32'h00001010, P, 8'hCF, 8'h85);
      acc(32'h00004000, P, 8'hCF, 8'h4F);
      acc_stop();
      wr(RS, 32'h00000007);
      attr(5'h1F, 1'b1, 3'b011);
      wr(RB, 32'h12345617);
      rd(RB, 32'h00000007);
      wr(CT, 32'h00000001);
      acc(32'hABCD0000, 6'h00, 8'hCF, 8'h07);
      acc(32'h00001010, W, 8'hCF, 8'h07);
      acc_stop();
      repeat (3) @(posedge clk_i);
      if (rd_q.size() != 0 || ck_q.size() != 0) begin
         fail("results missing");
      end
      test_done();
   end
endmodule

// [logic/rpc_params.svh]
// Constants of the region protection control block: offsets, field
// positions, reset values and size limits.
// Assumes it is included by its bare name; it defines macros only.
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map, byte offsets on the register bus
// ----------------------------------------------------------------------
`define RPC_OFS_CTRL 8'h00
`define RPC_OFS_RSEL 8'h04
`define RPC_OFS_RBASE 8'h08

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RPC_CTRL_ENABLE_BIT 0
`define RPC_CTRL_HFPROT_BIT 1
`define RPC_CTRL_BGMAP_BIT 2
`define RPC_RSEL_MSB 7
`define RPC_RBASE_VALID_BIT 4
`define RPC_RBASE_REGION_MSB 3
`define RPC_RBASE_ADDR_LSB 5

// ----------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------
`define RPC_NUM_REGIONS 8
`define RPC_NO_REGION 4'hF
`define RPC_SIZE_MIN 5'h07
`define RPC_SIZE_FULL 5'h1F
`define RPC_RSEL_RESET 8'h00
`define RPC_BASE_RESET 27'h0000000

`endif

// [logic/rpc_pkg.sv]
// Types and helper functions shared by the region protection files.
// Assumes rpc_params.svh is on the include path.
package rpc_pkg;
`include "rpc_params.svh"

   // ----------------------------------------------------------------------
   // State of the control block
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic live;
      logic ctrl_en;
      logic ctrl_hf;
      logic ctrl_bg;
      logic [7:0] rsel;
      logic [`RPC_NUM_REGIONS-1:0][26:0] base;
      logic ack;
      logic [31:0] rdata;
      logic chk_valid;
      logic fault;
      logic dflt;
      logic xn;
      logic so;
      logic [3:0] region;
   } rpc_state_t;

   // Log2 of the region size in bytes; sizes below the minimum are
   // clamped, since smaller settings have no defined meaning.
   function automatic logic [5:0] rpc_region_log2(input logic [4:0] size);
      logic [4:0] s;
      s = (size < `RPC_SIZE_MIN) ? `RPC_SIZE_MIN : size;
      return {1'b0, s} + 6'h01;
   endfunction

   // Mask of the base address bits; a full-map region has none.
   function automatic logic [31:0] rpc_addr_mask(input logic [4:0] size);
      logic [5:0] n;
      n = rpc_region_log2(size);
      if (n == 6'h20) begin
         return 32'h00000000;
      end
      return 32'hFFFFFFFF << n[4:0];
   endfunction
endpackage

// [logic/rpc_region_match.sv]
// One region comparator: tells whether an address falls in an enabled
// region and in one of its enabled subregions.
// Assumes the base was stored already masked to the region size.
`timescale 1ns/1ns
module rpc_region_match (
   // Region setup
   input wire logic [26:0] base_i,
   input wire logic [4:0] size_i,
   input wire logic enable_i,
   input wire logic [7:0] srd_i,
   // Access address and result
   input wire logic [31:0] addr_i,
   output logic hit_o
);
   import rpc_pkg::*;

   logic [31:0] mask;
   logic [5:0] sub_lsb;
   logic [31:0] sub_sh;
   logic [2:0] sub;

   // The region splits into eight equal subregions under its top bits.
   always_comb begin
      mask = rpc_addr_mask(size_i);
      sub_lsb = rpc_region_log2(size_i) - 6'h03;
      sub_sh = addr_i >> sub_lsb;
      sub = sub_sh[2:0];
      hit_o = enable_i && !srd_i[sub] &&
         (((addr_i ^ {base_i, 5'h00}) & mask) == 32'h00000000);
   end
endmodule

// [logic/rpc_top.sv]
// Region protection control: control bits, region selector, region base
// addresses on a Wishbone slave, and the per-access protection check.
// Assumes the region attribute and size settings arrive on ports from a
// neighbouring block that follows region_select_o, and that the core
// flags system control space and vector table accesses itself.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`include "rpc_params.svh"

module rpc_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Region attribute block
   output logic [7:0] region_select_o,
   input wire logic [8*5-1:0] region_size_i,
   input wire logic [7:0] region_enable_i,
   input wire logic [8*8-1:0] region_srd_i,
   input wire logic [8*3-1:0] region_ap_i,
   input wire logic [7:0] region_xn_i,
   input wire logic [7:0] region_c_i,
   input wire logic [7:0] region_b_i,
   // Access request from the core
   input wire logic acc_valid_i,
   input wire logic [31:0] acc_addr_i,
   input wire logic acc_write_i,
   input wire logic acc_fetch_i,
   input wire logic acc_priv_i,
   input wire logic acc_hfnmi_i,
   input wire logic acc_scs_i,
   input wire logic acc_vector_i,
   // Check result, one cycle after the request
   output logic chk_valid_o,
   output logic fault_o,
   output logic default_map_o,
   output logic execute_never_o,
   output logic strongly_ordered_o,
   output logic [3:0] hit_region_o
);
   import rpc_pkg::*;

   rpc_state_t q;
   rpc_state_t d;
   logic [7:0] hit;
   logic any_hit;
   logic [2:0] win;
   logic active;
   logic bus_req;
   logic [31:0] rd_val;
   logic [31:0] be_mask;
   logic [31:0] rd_mask;
   logic [31:0] wr_mask;
   logic [31:0] wv;
   logic [7:0] tgt;
   logic c_fault;
   logic c_dflt;
   logic c_xn;
   logic c_so;
   logic [3:0] c_reg;
   logic [2:0] w_ap;

   // ----------------------------------------------------------------------
   // Region comparators
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < 8; i++) begin : g_match
      rpc_region_match u_match (
         .base_i(q.base[i]),
         .size_i(region_size_i[i*5 +: 5]),
         .enable_i(region_enable_i[i]),
         .srd_i(region_srd_i[i*8 +: 8]),
         .addr_i(acc_addr_i),
         .hit_o(hit[i])
      );
   end

   // Access permission for one region; the reserved code denies all so
   // that an undefined setting never opens memory.
   function automatic logic rpc_ap_ok(input logic [2:0] ap,
         input logic priv, input logic wr);
      logic ok;
      ok = 1'b0;
      case (ap)
         3'h1: ok = priv;
         3'h2: ok = priv | ~wr;
         3'h3: ok = 1'b1;
         3'h5: ok = priv & ~wr;
         3'h6: ok = ~wr;
         3'h7: ok = ~wr;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // ----------------------------------------------------------------------
   // Protection check
   // ----------------------------------------------------------------------

   // The last matching index is kept, so the highest region wins.
   always_comb begin
      any_hit = 1'b0;
      win = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (hit[i]) begin
            any_hit = 1'b1;
            win = i[2:0];
         end
      end
   end

   // Handler priorities -1 and -2 switch checking off unless protected.
   assign active = q.ctrl_en & ~(acc_hfnmi_i & ~q.ctrl_hf);

   // Decision for the access presented in this cycle.
   always_comb begin
      c_fault = 1'b0;
      c_dflt = 1'b1;
      c_xn = acc_scs_i;
      c_so = acc_scs_i;
      c_reg = `RPC_NO_REGION;
      w_ap = region_ap_i[win*3 +: 3];
      if (!active) begin
         // Default map; the background bit plays no part here.
         c_dflt = 1'b1;
      end else if (acc_scs_i | acc_vector_i) begin
         c_dflt = 1'b1;
      end else if (any_hit) begin
         c_dflt = 1'b0;
         c_reg = {1'b0, win};
         c_xn = region_xn_i[win];
         c_so = ~region_c_i[win] & ~region_b_i[win];
         c_fault = ~rpc_ap_ok(w_ap, acc_priv_i, acc_write_i) |
            (acc_fetch_i & region_xn_i[win]);
      end else if (q.ctrl_bg & acc_priv_i) begin
         c_dflt = 1'b1;
      end else begin
         c_fault = 1'b1;
      end
      // Fetches from the control space are stopped in every mode.
      if (acc_scs_i & acc_fetch_i) begin
         c_fault = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i;

   // Byte lanes of a write; unselected lanes take the read value of the addressed register.
   assign be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Read view of the addressed register.
   always_comb begin
      rd_val = 32'h00000000;
      rd_mask = rpc_addr_mask(region_size_i[q.rsel[2:0]*5 +: 5]);
      case ({wb_adr_i[7:2], 2'h0})
         `RPC_OFS_CTRL: begin
            rd_val = {29'h0, q.ctrl_bg, q.ctrl_hf, q.ctrl_en};
         end
         `RPC_OFS_RSEL: begin
            rd_val = {24'h0, q.rsel};
         end
         `RPC_OFS_RBASE: begin
            // Valid reads zero; region bits show the selector.
            rd_val = {27'h0, 1'b0, q.rsel[3:0]};
            if (q.rsel < 8'h08) begin
               rd_val[31:5] = q.base[q.rsel[2:0]] &
                  rd_mask[31:5];
            end
         end
         default: begin
            rd_val = 32'h00000000;
         end
      endcase
   end

   assign wv = (rd_val & ~be_mask) | (wb_dat_i & be_mask);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      d = q;
      d.live = 1'b1;
      tgt = q.rsel;
      wr_mask = 32'h00000000;
      // One wait state: ack rises the cycle after the request.
      d.ack = bus_req & ~q.ack;
      if (bus_req & ~q.ack) begin
         d.rdata = rd_val;
      end
      // A write lands at the edge where the master samples ack.
      if (bus_req & q.ack & wb_we_i) begin
         case ({wb_adr_i[7:2], 2'h0})
            `RPC_OFS_CTRL: begin
               d.ctrl_en = wv[`RPC_CTRL_ENABLE_BIT];
               d.ctrl_hf = wv[`RPC_CTRL_HFPROT_BIT];
               d.ctrl_bg = wv[`RPC_CTRL_BGMAP_BIT];
            end
            `RPC_OFS_RSEL: begin
               d.rsel = wv[`RPC_RSEL_MSB:0];
            end
            `RPC_OFS_RBASE: begin
               if (wv[`RPC_RBASE_VALID_BIT]) begin
                  tgt = {4'h0, wv[`RPC_RBASE_REGION_MSB:0]};
                  d.rsel = tgt;
               end else begin
                  tgt = q.rsel;
               end
               // Selector values past the last region write nothing.
               if (tgt < 8'h08) begin
                  wr_mask = rpc_addr_mask(region_size_i[tgt[2:0]*5 +: 5]);
                  d.base[tgt[2:0]] = wv[31:`RPC_RBASE_ADDR_LSB] &
                     wr_mask[31:5];
               end
            end
            default: begin
               d.rsel = q.rsel;
            end
         endcase
      end
      // Check results; the fault is a pulse tied to the valid strobe.
      d.chk_valid = acc_valid_i;
      d.fault = acc_valid_i & c_fault;
      if (acc_valid_i) begin
         d.dflt = c_dflt;
         d.xn = c_xn;
         d.so = c_so;
         d.region = c_reg;
      end
   end

   // State register; the selector reset value is fixed so that the
   // attribute block follows a defined region out of reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.rsel <= `RPC_RSEL_RESET;
         q.base <= {`RPC_NUM_REGIONS{`RPC_BASE_RESET}};
         q.region <= `RPC_NO_REGION;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign wb_dat_o = q.rdata;
   assign wb_ack_o = q.ack;
   assign region_select_o = q.rsel;
   assign chk_valid_o = q.chk_valid;
   assign fault_o = q.fault;
   assign default_map_o = q.dflt;
   assign execute_never_o = q.xn;
   assign strongly_ordered_o = q.so;
   assign hit_region_o = q.region;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_disabled_default: assert property (q.live && $past(acc_valid_i &&
      !q.ctrl_en && !(acc_scs_i && acc_fetch_i)) |->
      chk_valid_o && !fault_o && default_map_o)
      else $error("disabled unit did not use the default map");

   a_nobg_miss_fault: assert property (q.live && $past(acc_valid_i &&
      active && !acc_scs_i && !acc_vector_i && !any_hit && !q.ctrl_bg)
      |-> fault_o)
      else $error("miss without background did not fault");

   a_bg_priv_miss: assert property (q.live && $past(acc_valid_i &&
      active && !acc_scs_i && !acc_vector_i && !any_hit && q.ctrl_bg &&
      acc_priv_i) |-> !fault_o && default_map_o &&
      hit_region_o == `RPC_NO_REGION)
      else $error("privileged miss did not use the background");

   a_bg_unpriv_miss: assert property (q.live && $past(acc_valid_i &&
      active && !acc_scs_i && !acc_vector_i && !any_hit && !acc_priv_i)
      |-> fault_o)
      else $error("unprivileged miss did not fault");

   a_handler_bypass: assert property (q.live && $past(acc_valid_i &&
      acc_hfnmi_i && !q.ctrl_hf && !(acc_scs_i && acc_fetch_i)) |->
      !fault_o && default_map_o)
      else $error("handler access was checked");

   a_scs_attrs: assert property (q.live && $past(acc_valid_i &&
      acc_scs_i) |-> execute_never_o && strongly_ordered_o)
      else $error("control space lost execute-never or ordering");

   a_scs_vec_ok: assert property (q.live && $past(acc_valid_i &&
      (acc_vector_i || acc_scs_i) && !(acc_scs_i && acc_fetch_i)) |->
      !fault_o)
      else $error("control space or vector access faulted");

   a_overlap_win: assert property (q.live && $past(acc_valid_i &&
      active && !acc_scs_i && !acc_vector_i && hit[7]) |->
      hit_region_o == 4'h7 && !default_map_o)
      else $error("highest region did not win");

   a_rbase_redirect: assert property (bus_req && q.ack && wb_we_i &&
      wb_sel_i[0] && {wb_adr_i[7:2], 2'h0} == `RPC_OFS_RBASE &&
      wb_dat_i[4] |=> q.rsel == {4'h0, $past(wb_dat_i[3:0])})
      else $error("valid base write did not move the selector");

   a_rbase_keep: assert property (bus_req && q.ack && wb_we_i &&
      {wb_adr_i[7:2], 2'h0} == `RPC_OFS_RBASE && !(wb_sel_i[0] &&
      wb_dat_i[4]) |=> $stable(q.rsel))
      else $error("plain base write changed the selector");

   a_rbase_read: assert property (wb_ack_o && !wb_we_i &&
      {wb_adr_i[7:2], 2'h0} == `RPC_OFS_RBASE |->
      wb_dat_o[4:0] == {1'b0, q.rsel[3:0]})
      else $error("base read showed wrong valid or region bits");

   a_ctrl_reserved: assert property (wb_ack_o && !wb_we_i &&
      {wb_adr_i[7:2], 2'h0} == `RPC_OFS_CTRL |->
      wb_dat_o[31:3] == 29'h0)
      else $error("control reserved bits not zero");
endmodule
